// ==== core/adc_input_defs.svh ====
`ifndef ADC_INPUT_DEFS_SVH
`define ADC_INPUT_DEFS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses)
// ------------------------------------------------------------
`define ADC_OFS_CTRL 8'h00
`define ADC_OFS_START 8'h04
`define ADC_OFS_STATUS 8'h08
`define ADC_OFS_CFG0 8'h10
`define ADC_OFS_RES0 8'h20

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ADC_CTRL_ENABLE 0
`define ADC_CTRL_SIGNED 1
`define ADC_CTRL_TEMP_EN 2
`define ADC_CTRL_BG_EN 3
`define ADC_CTRL_DAC_EN 4
`define ADC_CFG_TYPE_LSB 0
`define ADC_CFG_GAIN_LSB 2
`define ADC_CFG_POS_LSB 8
`define ADC_CFG_NEG_LSB 12
`define ADC_ST_CONFLICT_LSB 0
`define ADC_ST_REFUSED_LSB 4
`define ADC_ST_DONE_LSB 8

// ------------------------------------------------------------
// Negative input codes and reset values
// ------------------------------------------------------------
`define ADC_NEG_PAD_GND 3'h4
`define ADC_NEG_INT_GND 3'h5
`define ADC_GAIN_PIN_BASE 4'h4
`define ADC_RST_CTRL 5'h00

`endif

// ==== core/adc_input_pkg.sv ====
package adc_input_pkg;

    // Measurement type per channel
    typedef enum logic [1:0] {
        MEAS_DIFF = 2'h0,
        MEAS_DIFF_GAIN = 2'h1,
        MEAS_SINGLE = 2'h2,
        MEAS_INTERNAL = 2'h3
    } meas_e;

    // Gain stage setting, half up to sixty-four times
    typedef enum logic [2:0] {
        GAIN_HALF = 3'h0, GAIN_1X = 3'h1, GAIN_2X = 3'h2, GAIN_4X = 3'h3,
        GAIN_8X = 3'h4, GAIN_16X = 3'h5, GAIN_32X = 3'h6, GAIN_64X = 3'h7
    } gain_e;

    // Internal sources, selected by the positive field
    typedef enum logic [2:0] {
        INT_TEMP = 3'h0, INT_BANDGAP = 3'h1, INT_VCC_DIV10 = 3'h2,
        INT_DAC = 3'h3, INT_PAD_GND = 3'h4, INT_INT_GND = 3'h5
    } int_src_e;

    // Where the negative converter input goes
    typedef enum logic [1:0] {
        NEG_PIN = 2'h0, NEG_PAD_GND = 2'h1, NEG_INT_GND = 2'h2,
        NEG_HALF_REF = 2'h3
    } neg_kind_e;

    // One channel's stored configuration
    typedef struct packed {
        logic [2:0] neg;
        logic [3:0] pos;
        gain_e gain;
        meas_e mtype;
    } ch_cfg_s;

    // Sample request towards the converter core and multiplexer
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic pos_is_pin;
        logic [3:0] pos_pin;
        int_src_e int_src;
        neg_kind_e neg_kind;
        logic [2:0] neg_pin;
        logic gain_en;
        gain_e gain;
        logic signed_mode;
    } conv_req_s;

    // Finished conversion coming back from the core
    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic [11:0] data;
    } conv_res_s;

endpackage

// ==== core/pipelined_adc_input_select.sv ====
// Contract
// - Four channels, own input, result, start
// - Results are twelve bits wide
// - New sample accepted while conversions proceed
// - Results movable by DMA without processor
// - Plain differential: negative only pins zero-three
// - Gain differential: negative pins four-seven, signed
// - Gain type routes sample through gain stage
// - Eight gain choices, half to sixty-four
// - Single-ended: any pin, signed or unsigned
// - Signed single-ended negative is internal ground
// - Unsigned single/internal negative is half reference
// - Internal sources: temp, bandgap, supply, DAC, grounds
// - Supply source is divided by ten
// - Differential negative may be pad/internal ground
// - Signed internal measurement uses internal ground
// - Signed/unsigned is one global setting
// - Start by software bit or event, several
`include "adc_input_defs.svh"

module pipelined_adc_input_select
    import adc_input_pkg::*;
#(
    parameter int NUM_CH = 4,
    parameter int RES_W = 12
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [3:0] ev_start,
    output logic [3:0] dma_req,
    output conv_req_s conv_req,
    input wire conv_res_s conv_res,
    output logic temp_en,
    output logic bandgap_en,
    output logic dac_en
);

    // --------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------
    // The register map and request tags are laid out for this shape only
    if (NUM_CH != 4 || RES_W != 12) begin : g_bad_shape
        $error("Only four channels of twelve bits are supported");
    end

    // --------------------------------------------------------
    // State
    // --------------------------------------------------------
    typedef struct packed {
        logic enable;         // Converter enabled
        logic signed_mode;    // Global, one for all channels
        logic [2:0] int_en;   // Temp, bandgap, DAC source enables
        ch_cfg_s [3:0] cfg;   // Per-channel input selection
        logic [3:0] pend;     // Start requests waiting for the pipe
        logic [3:0] refused;  // Sticky, start dropped on bad setup
        logic [3:0] done;     // Result waiting for a reader
        logic [3:0][11:0] res; // Per-channel result storage
        logic [31:0] rdata;   // Read data, one cycle after strobe
        conv_req_s req;       // Sample issued to the core
    } st_s;

    st_s st_q;
    st_s st_d;

    // --------------------------------------------------------
    // Legality of one channel setup
    // --------------------------------------------------------
    function automatic logic cfg_ok(input ch_cfg_s c, input logic sgn,
                                    input logic [2:0] en);
        logic ok;
        ok = 1'b0;
        case (c.mtype)
            // Pins 0-3 or either ground; signed only
            MEAS_DIFF: ok = sgn && (c.neg <= `ADC_NEG_INT_GND);
            // Codes 0-3 stand for pins 4-7; signed only
            MEAS_DIFF_GAIN: ok = sgn && (c.neg <= `ADC_NEG_INT_GND);
            // Any pin, either mode
            MEAS_SINGLE: ok = 1'b1;
            MEAS_INTERNAL: begin
                // Sources that need their own enable first
                case (c.pos[2:0])
                    INT_TEMP: ok = en[0];
                    INT_BANDGAP: ok = en[1];
                    INT_DAC: ok = en[2];
                    default: ok = (c.pos <= 4'(INT_INT_GND));
                endcase
                // Codes eight and up alias the low ones but name no source
                ok = ok && !c.pos[3];
            end
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // --------------------------------------------------------
    // Build the multiplexer request for one channel
    // --------------------------------------------------------
    function automatic conv_req_s decode(input ch_cfg_s c,
                                         input logic [1:0] ch,
                                         input logic sgn);
        conv_req_s r;
        r = '0;
        r.valid = 1'b1;
        r.chan = ch;
        r.signed_mode = sgn;
        r.gain = c.gain;
        r.pos_pin = c.pos;
        r.pos_is_pin = (c.mtype != MEAS_INTERNAL);
        // Vcc source is the divided-by-ten tap inside the mux
        r.int_src = int_src_e'(c.pos[2:0]);
        case (c.mtype)
            MEAS_DIFF, MEAS_DIFF_GAIN: begin
                // Grounds are extra negative choices for differential
                if (c.neg == `ADC_NEG_PAD_GND) begin
                    r.neg_kind = NEG_PAD_GND;
                end else if (c.neg == `ADC_NEG_INT_GND) begin
                    r.neg_kind = NEG_INT_GND;
                end else begin
                    r.neg_kind = NEG_PIN;
                    r.neg_pin = c.neg;
                end
                if (c.mtype == MEAS_DIFF_GAIN) begin
                    // Sample through the amplifier before the pipeline
                    r.gain_en = 1'b1;
                    if (c.neg < `ADC_NEG_PAD_GND) begin
                        r.neg_pin = 3'(`ADC_GAIN_PIN_BASE) | c.neg;
                    end
                end
            end
            default: begin
                // Single-ended or internal: fixed negative level
                r.neg_kind = sgn ? NEG_INT_GND
                                 : NEG_HALF_REF;
            end
        endcase
        return r;
    endfunction

    // --------------------------------------------------------
    // Live conflict: differential type while unsigned
    // --------------------------------------------------------
    logic [3:0] conflict;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            conflict[i] = !st_q.signed_mode &&
                (st_q.cfg[i].mtype == MEAS_DIFF ||
                 st_q.cfg[i].mtype == MEAS_DIFF_GAIN);
        end
    end

    // --------------------------------------------------------
    // Next state
    // --------------------------------------------------------
    always_comb begin
        logic [3:0] start_set;
        logic [3:0] take;
        logic [3:0] done_set;
        logic [3:0] done_clr;
        logic [3:0] ref_clr;
        logic [3:0] ref_set;
        logic [1:0] idx;
        logic found;
        start_set = '0;
        ref_set = '0;
        take = '0;
        done_set = '0;
        done_clr = '0;
        ref_clr = '0;
        idx = '0;
        found = 1'b0;
        st_d = st_q;
        st_d.req = '0;
        st_d.rdata = '0;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                `ADC_OFS_CTRL: begin
                    st_d.enable = reg_wdata[`ADC_CTRL_ENABLE];
                    st_d.signed_mode = reg_wdata[`ADC_CTRL_SIGNED];
                    st_d.int_en = reg_wdata[`ADC_CTRL_DAC_EN:`ADC_CTRL_TEMP_EN];
                end
                // Several bits at once start several channels
                `ADC_OFS_START: start_set = reg_wdata[3:0];
                // Refused flags are write-one-to-clear
                `ADC_OFS_STATUS: ref_clr = reg_wdata[7:4];
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (reg_addr == `ADC_OFS_CFG0 + 8'(4 * i)) begin
                            st_d.cfg[i] = ch_cfg_s'({reg_wdata[14:12],
                                reg_wdata[11:8], reg_wdata[4:2],
                                reg_wdata[1:0]});
                        end
                    end
                end
            endcase
        end

        // Register reads; a result read hands the word over
        if (reg_rd) begin
            case (reg_addr)
                `ADC_OFS_CTRL: st_d.rdata = {27'h0, st_q.int_en,
                    st_q.signed_mode, st_q.enable};
                `ADC_OFS_START: st_d.rdata = {28'h0, st_q.pend};
                `ADC_OFS_STATUS: st_d.rdata = {20'h0, st_q.done,
                    st_q.refused, conflict};
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (reg_addr == `ADC_OFS_CFG0 + 8'(4 * i)) begin
                            st_d.rdata = {17'h0, st_q.cfg[i].neg,
                                st_q.cfg[i].pos, 3'h0, st_q.cfg[i].gain,
                                st_q.cfg[i].mtype};
                        end
                        if (reg_addr == `ADC_OFS_RES0 + 8'(4 * i)) begin
                            st_d.rdata = {20'h0, st_q.res[i]};
                            done_clr[i] = 1'b1;
                        end
                    end
                end
            endcase
        end

        // Collect starts from software and events
        start_set = start_set | ev_start;

        // Lowest pending channel goes into the pipe each cycle
        for (int i = 3; i >= 0; i--) begin
            if (st_q.pend[i]) begin
                idx = 2'(i);
                found = 1'b1;
            end
        end
        if (st_q.enable && found) begin
            take[idx] = 1'b1;
            // No wait for earlier results: one sample per cycle
            if (cfg_ok(st_q.cfg[idx], st_q.signed_mode, st_q.int_en)) begin
                st_d.req = decode(st_q.cfg[idx], idx,
                                  st_q.signed_mode);
            end else begin
                ref_set[idx] = 1'b1;
            end
        end

        // Results land in their own channel slot only
        if (conv_res.valid) begin
            st_d.res[conv_res.chan] = conv_res.data;
            done_set[conv_res.chan] = 1'b1;
        end

        // Set wins over clear for every flag
        st_d.pend = (st_q.pend & ~take) | start_set;
        st_d.done = (st_q.done & ~done_clr) | done_set;
        st_d.refused = (st_q.refused & ~ref_clr) | ref_set;
    end

    // --------------------------------------------------------
    // State register
    // --------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // --------------------------------------------------------
    // Outputs
    // --------------------------------------------------------
    assign reg_rdata = st_q.rdata;
    assign conv_req = st_q.req;
    // Each channel has its own transfer request
    assign dma_req = st_q.done;
    assign temp_en = st_q.int_en[0];
    assign bandgap_en = st_q.int_en[1];
    assign dac_en = st_q.int_en[2];

    // --------------------------------------------------------
    // Checks
    // --------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    // Lowest pending channel, for the scan checks
    logic found_any;
    logic [1:0] low_pend;
    assign found_any = |st_q.pend;

    always_comb begin
        low_pend = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (st_q.pend[i]) begin
                low_pend = 2'(i);
            end
        end
    end

    sequence s_start_seen;
        st_q.enable && found_any && !st_q.pend[0] && st_q.pend[1];
    endsequence

    diff_unsigned_a: assert property (
        conv_req.valid && (conv_req.neg_kind == NEG_PIN)
        |-> conv_req.signed_mode)
        else $error("Differential sample issued in unsigned mode");

    gain_neg_pin_a: assert property (
        conv_req.valid && conv_req.gain_en && conv_req.neg_kind == NEG_PIN
        |-> conv_req.neg_pin[2])
        else $error("Gain negative pin outside four to seven");

    plain_neg_pin_a: assert property (
        conv_req.valid && !conv_req.gain_en && conv_req.neg_kind == NEG_PIN
        |-> !conv_req.neg_pin[2])
        else $error("Plain negative pin outside zero to three");

    single_neg_a: assert property (
        conv_req.valid && conv_req.neg_kind != NEG_PIN &&
        conv_req.neg_kind != NEG_PAD_GND && !conv_req.gain_en
        && conv_req.pos_is_pin && conv_req.signed_mode
        |-> conv_req.neg_kind == NEG_INT_GND)
        else $error("Signed single-ended negative not internal ground");

    unsigned_half_a: assert property (
        conv_req.valid && !conv_req.signed_mode
        |-> conv_req.neg_kind == NEG_HALF_REF && !conv_req.gain_en)
        else $error("Unsigned sample not against half reference");

    pipe_issue_a: assert property (
        st_q.enable && found_any |=> (conv_req.valid &&
        conv_req.chan == $past(low_pend)) || st_q.refused[$past(low_pend)])
        else $error("Pending start not taken next cycle");

    start_order_a: assert property (
        s_start_seen ##1 !st_q.pend[1] |-> (conv_req.valid &&
        conv_req.chan == 2'h1) || st_q.refused[1])
        else $error("Scan did not take the lowest channel");

    result_store_a: assert property (
        conv_res.valid |=> st_q.res[$past(conv_res.chan)] ==
        $past(conv_res.data) && st_q.done[$past(conv_res.chan)])
        else $error("Result not stored in its channel");

    dma_follow_a: assert property (
        conv_res.valid ##1 !reg_rd[*2] |-> dma_req[$past(conv_res.chan, 2)])
        else $error("Transfer request dropped before a read");

endmodule

// ==== tb/adc_core_model.sv ====
// ------------------------------------------------------------
// Converter core and input multiplexer stand-in
// ------------------------------------------------------------
module adc_core_model
    import adc_input_pkg::*;
#(
    parameter int LAT = 5
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire conv_req_s conv_req,
    output conv_res_s conv_res
);
    timeunit 1ns;
    timeprecision 100ps;

    conv_res_s pipe_q [LAT]; // LAT stages; with the conv_res register a result takes LAT+1 cycles
    logic [11:0] seq_q; // Running sample value, 12 bits wide

    // Takes a sample every cycle, never waits for older ones
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < LAT; i++) begin
                pipe_q[i] <= '0;
            end
            seq_q <= 12'h5A3;
            conv_res <= '0;
        end else begin
            pipe_q[0].valid <= conv_req.valid;
            pipe_q[0].chan <= conv_req.chan;
            pipe_q[0].data <= seq_q;
            for (int i = 1; i < LAT; i++) begin
                pipe_q[i] <= pipe_q[i-1];
            end
            if (conv_req.valid) begin
                seq_q <= seq_q + 12'h1D7;
            end
            // Outside a result the lines flip, so stale data never matches
            if (pipe_q[LAT-1].valid) begin
                conv_res <= pipe_q[LAT-1];
            end else begin
                conv_res <= {1'b0, ~conv_res.chan, ~conv_res.data};
            end
        end
    end
endmodule

// ==== tb/tb_pipelined_adc_input_select.sv ====
`include "adc_input_defs.svh"

module tb_pipelined_adc_input_select
    import adc_input_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk, arst_n, reg_wr, reg_rd, temp_en, bandgap_en, dac_en;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [3:0] ev_start, dma_req;
    conv_req_s conv_req;
    conv_res_s conv_res;
    int error_cnt = 0;
    int n_checks = 0;
    logic [15:0] lfsr = 16'h0034; // Random source, fixed start
    conv_req_s exp_q [$]; // Requests still owed by the design
    logic [11:0] res_exp [4]; // Last result handed to each channel
    logic [3:0] done_exp = 4'h0, refused_exp, conflict_exp;

    pipelined_adc_input_select pipelined_adc_input_select_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ev_start(ev_start), .dma_req(dma_req),
        .conv_req(conv_req), .conv_res(conv_res), .temp_en(temp_en),
        .bandgap_en(bandgap_en), .dac_en(dac_en));
    adc_core_model adc_core_model_i (.sys_clk(sys_clk), .arst_n(arst_n),
        .conv_req(conv_req), .conv_res(conv_res));

    always #5 sys_clk = ~sys_clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Clears fields that carry no meaning for the chosen routing
    function automatic conv_req_s norm(conv_req_s r);
        conv_req_s n;
        n = r;
        if (!n.pos_is_pin) n.pos_pin = 4'h0;
        else n.int_src = INT_TEMP;
        if (n.neg_kind != NEG_PIN) n.neg_pin = 3'h0;
        if (!n.gain_en) n.gain = GAIN_HALF;
        return n;
    endfunction

    // Request the rules call for, built from the stored setup
    function automatic conv_req_s exp_req(int ch, ch_cfg_s c, logic sgn);
        conv_req_s e;
        logic dif;
        e = '0;
        dif = (c.mtype == MEAS_DIFF) || (c.mtype == MEAS_DIFF_GAIN);
        e.valid = 1'b1;
        e.chan = 2'(ch);
        e.signed_mode = sgn;
        e.pos_is_pin = c.mtype != MEAS_INTERNAL;
        e.pos_pin = c.pos;
        e.int_src = int_src_e'(c.pos[2:0]);
        e.gain_en = c.mtype == MEAS_DIFF_GAIN;
        e.gain = c.gain;
        if (!dif) e.neg_kind = sgn ? NEG_INT_GND : NEG_HALF_REF;
        else if (c.neg == 3'h4) e.neg_kind = NEG_PAD_GND;
        else if (c.neg == 3'h5) e.neg_kind = NEG_INT_GND;
        else e.neg_pin = c.neg + (e.gain_en ? 3'h4 : 3'h0);
        return norm(e);
    endfunction

    function automatic logic legal(ch_cfg_s c, logic sgn, logic [2:0] ens);
        if (c.mtype == MEAS_SINGLE) return 1'b1;
        if (c.mtype == MEAS_INTERNAL) begin
            if (c.pos > 4'h5) return 1'b0;
            if (c.pos == 4'h0) return ens[0];
            if (c.pos == 4'h1) return ens[1];
            if (c.pos == 4'h3) return ens[2];
            return 1'b1;
        end
        return sgn && (c.neg <= 3'h5);
    endfunction

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Watches requests and results where outputs have settled
    always @(negedge sys_clk) begin
        if (arst_n && conv_req.valid === 1'b1) begin
            if (exp_q.size() == 0) check("conv_req extra", 1, 0);
            else check("conv_req", 32'(norm(conv_req)),
                32'(exp_q.pop_front()));
        end
        if (arst_n && conv_res.valid === 1'b1) begin
            res_exp[conv_res.chan] = conv_res.data;
            done_exp[conv_res.chan] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // One round: setup with the converter held, start, release
    // ------------------------------------------------------------
    task automatic round(int r);
        logic [31:0] ctrl, d;
        logic [3:0] mask;
        logic [2:0] ens;
        logic sgn;
        ch_cfg_s c;
        sgn = r < 6; // Signed only while differential is wanted
        ens = (r % 3 == 2) ? 3'h0 : 3'h7; // Sources on first
        ctrl = {27'h0, ens, sgn, 1'b0};
        wr(`ADC_OFS_CTRL, ctrl);
        wr(`ADC_OFS_STATUS, 32'h0000_00F0);
        refused_exp = 4'h0;
        conflict_exp = 4'h0;
        lfsr = lfsr_next(lfsr);
        // Channel one, and three early on, carry the gain walk
        mask = lfsr[3:0] | 4'h2 | (4'h1 << (r % 4));
        if (r < 2) mask[3] = 1'b1;
        for (int ch = 0; ch < 4; ch++) begin
            lfsr = lfsr_next(lfsr);
            c.mtype = meas_e'(lfsr[1:0]);
            c.gain = gain_e'(lfsr[4:2]);
            c.pos = lfsr[8:5];
            c.neg = lfsr[11:9];
            if (ch == 1 || (ch == 3 && r < 2)) begin
                // Six signed rounds on one, two more on three
                c.mtype = MEAS_DIFF_GAIN;
                c.gain = gain_e'(3'(ch == 1 ? r : r + 6));
                c.neg = 3'(ch == 1 ? r % 4 : r + 4);
            end
            if (c.mtype[1]) c.neg = 3'h0;
            if (c.mtype == MEAS_INTERNAL) c.pos[3] = 1'b0;
            wr(`ADC_OFS_CFG0 + 8'(4 * ch), 32'({c.neg, c.pos,
                3'h0, c.gain, c.mtype}));
            if (!c.mtype[1] && !sgn) conflict_exp[ch] = 1'b1;
            if (mask[ch] && legal(c, sgn, ens)) exp_q.push_back(
                exp_req(ch, c, sgn));
            else if (mask[ch]) refused_exp[ch] = 1'b1;
        end
        if (r % 2 == 1) begin
            @(posedge sys_clk);
            ev_start <= mask;
            @(posedge sys_clk);
            ev_start <= 4'h0;
        end else begin
            wr(`ADC_OFS_START, 32'(mask));
        end
        rd(`ADC_OFS_START, d);
        check("pending", d, 32'(mask));
        check("enables", 32'({dac_en, bandgap_en, temp_en}),
            32'(ens));
        wr(`ADC_OFS_CTRL, ctrl | 32'h1);
        repeat (20) @(posedge sys_clk);
        check("req left", 32'(exp_q.size()), 0);
        rd(`ADC_OFS_STATUS, d);
        check("status", d, {20'h0, done_exp, refused_exp,
            conflict_exp});
        check("dma_req", 32'(dma_req), 32'(done_exp));
        for (int ch = 0; ch < 4; ch++) begin
            if (done_exp[ch]) begin
                rd(`ADC_OFS_RES0 + 8'(4 * ch), d);
                check("result", d, 32'(res_exp[ch]));
                done_exp[ch] = 1'b0;
            end
        end
        check("dma_req clear", 32'(dma_req), 0);
        $display("round %0d done", r);
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        sys_clk = 1'b0;
        arst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ev_start = 4'h0;
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        #1 check("reset rdata", reg_rdata, 0);
        check("reset outputs", 32'({dma_req, conv_req.valid}), 0);
        rd(`ADC_OFS_CTRL, d);
        check("ctrl reset", d, 32'(`ADC_RST_CTRL));
        rd(8'h0C, d);
        check("unmapped", d, 0);
        $display("reset test done");
        for (int r = 0; r < 8; r++) round(r);
        complete_run();
    end

    // Eight rounds need well under two thousand cycles
    initial begin
        #100us;
        error_cnt++;
        complete_run();
    end
endmodule
